// [design/rclp_pkg.sv]
package rclp_pkg;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_QUOTE = 8'h22;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_QMARK = 8'h3F;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_UNDER = 8'h5F;
  localparam int MAX_LINE = 80;
  localparam logic [16:0] UI_MAX = 17'h0FFFF;
  localparam logic [16:0] ND_MAX = 17'h000FF;
  localparam logic [16:0] VAL_SAT = 17'h10000;
  // Command catalogue: name right-justified, full length, significant length
  localparam int NCMD = 4;
  localparam int NAME_CHARS = 12;
  localparam int IDW = 2;
  localparam logic [NAME_CHARS*8-1:0] CMD_NAME [NCMD] = '{
    "START_TEST", "STOP_TEST", "OUT_LEVEL", "STATUS"};
  localparam logic [3:0] CMD_LEN [NCMD] = '{4'hA, 4'h9, 4'h9, 4'h6};
  localparam logic [3:0] CMD_SIG [NCMD] = '{4'h3, 4'h3, 4'h2, 4'h3};
  // End of line choices on the serial port
  localparam logic [1:0] EOL_CR = 2'h0;
  localparam logic [1:0] EOL_LF = 2'h1;
  localparam logic [1:0] EOL_CRLF = 2'h2;
  localparam logic [1:0] EOL_LFCR = 2'h3;
  typedef enum logic [2:0] {
    ARG_UI, ARG_NR1, ARG_NR2, ARG_NR3, ARG_NONDEC, ARG_STR
  } rclp_arg_t;
endpackage

// [design/rclp_match_if.sv]
interface rclp_match_if;
  logic clr;
  logic ch_valid;
  logic [7:0] ch;
  logic hit;
  logic [rclp_pkg::IDW-1:0] id;
  modport parser (output clr, output ch_valid, output ch, input hit, input id);
  modport matcher (input clr, input ch_valid, input ch, output hit, output id);
endinterface

// [design/rclp_hdr_match.sv]
module rclp_hdr_match (
  input wire logic clock,
  input wire logic arst_n,
  rclp_match_if.matcher m
);
  logic [rclp_pkg::NCMD-1:0] alive;
  logic [3:0] idx;

  // Index saturates at 15, so catalogue names must stay shorter
  if (rclp_pkg::NCMD > (1 << rclp_pkg::IDW) || rclp_pkg::NAME_CHARS > 14) begin
    $error("command catalogue does not fit the matcher");
  end

  // Every entry is tracked in parallel, one character a cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      alive <= '1;
      idx <= 4'h0;
    end else if (m.clr) begin
      alive <= '1;
      idx <= 4'h0;
    end else if (m.ch_valid) begin
      for (int i = 0; i < rclp_pkg::NCMD; i++) begin
        if (idx >= rclp_pkg::CMD_LEN[i] ||
            rclp_pkg::CMD_NAME[i][(rclp_pkg::CMD_LEN[i] - 4'h1 - idx) * 8 +: 8] != m.ch) begin
          alive[i] <= 1'b0;
        end
      end
      if (idx != 4'hF) begin
        idx <= idx + 4'h1;
      end
    end
  end

  // Full name or any truncation keeping the significant part
  always_comb begin
    m.hit = 1'b0;
    m.id = '0;
    for (int i = rclp_pkg::NCMD - 1; i >= 0; i--) begin
      if (alive[i] && idx >= rclp_pkg::CMD_SIG[i]) begin
        m.hit = 1'b1;
        m.id = i[rclp_pkg::IDW-1:0];
      end
    end
  end
endmodule

// [design/rclp_parser.sv]
// How it works
// - Serial responses end with chosen CR, LF, CR LF or LF CR.
// - GPIB line ends on EOI, alone or with a line feed, code 10.
// - GPIB responses end with EOI alone or EOI with line feed.
// - Semicolons split a line into commands, handled in order.
// - Headers match full name or truncation keeping significant characters.
// - Header ending in question mark is the query form.
// - Letter case never matters.
// - Other spaces between headers, arguments and separators are ignored.
// - Non-decimal integers 0 to 255 with #H, #Q or #B prefix.
// - Unsigned integers 0 up to 65535 are accepted.
// - Signed integer, float without exponent, float with exponent are distinguished.
// - A string argument is the text between two quotes.
// - Set commands change setup; queries ask for a response.
// - Arguments outside their allowed range reject the command.
module rclp_parser (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic port_gpib,
  input wire logic [1:0] eol_sel,
  input wire logic gpib_lf_en,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_eoi,
  output logic rx_ready,
  output logic cmd_valid,
  output logic cmd_reject,
  output logic cmd_query,
  output logic [rclp_pkg::IDW-1:0] cmd_id,
  output logic arg_valid,
  output rclp_pkg::rclp_arg_t arg_kind,
  output logic arg_neg,
  output logic [15:0] arg_value,
  output logic line_done,
  output logic line_overflow,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic resp_last,
  output logic resp_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_eoi,
  input wire logic tx_ready
);
  typedef enum logic [2:0] {P_HDR, P_SEP, P_ARG, P_BASE, P_STR, P_SKIP} rclp_pst_t;
  typedef enum logic [1:0] {T_DATA, T_EOL1, T_EOL2} rclp_tst_t;

  rclp_match_if mif ();
  rclp_hdr_match u_match (.clock(clock), .arst_n(arst_n), .m(mif));

  // Line counter and header length are seven bits wide
  if (rclp_pkg::MAX_LINE > 126) begin
    $error("line limit too large for the line counter");
  end

  rclp_pst_t pst;
  rclp_tst_t tst;
  logic end_pend, hdr_sp, query, err, ovf, ahave, aneg, first_arg;
  logic [6:0] hlen, lcount;
  logic [4:0] base;
  logic [16:0] aval;
  rclp_pkg::rclp_arg_t akind;

  logic take, is_end, is_last, sep_end;
  logic [7:0] u;
  logic [4:0] dig;
  logic dig_ok;
  logic [21:0] acc;

  assign take = rx_valid && rx_ready;
  assign u = (rx_data >= 8'h61 && rx_data <= 8'h7A) ? rx_data - 8'h20 : rx_data;
  // Serial line ends on CR, GPIB on EOI with LF
  assign is_end = take && (port_gpib ? (rx_eoi && rx_data == rclp_pkg::CH_LF)
                                     : rx_data == rclp_pkg::CH_CR);
  assign is_last = take && port_gpib && rx_eoi && rx_data != rclp_pkg::CH_LF;
  assign sep_end = take && !is_end && u == rclp_pkg::CH_SEMI && pst != P_STR;

  always_comb begin
    dig = 5'h1F;
    if (u >= 8'h30 && u <= 8'h39) begin
      dig = 5'(u - 8'h30);
    end else if (u >= 8'h41 && u <= 8'h46) begin
      dig = 5'(u - 8'h37);
    end
    dig_ok = dig < base;
    acc = 22'(aval) * 22'(base) + 22'(dig);
  end

  assign mif.clr = sep_end || is_end || end_pend;
  assign mif.ch_valid = take && !is_end && pst == P_HDR && !ovf &&
                        u != rclp_pkg::CH_SP && u != rclp_pkg::CH_SEMI &&
                        u != rclp_pkg::CH_QMARK;
  assign mif.ch = u;

  // Command close: emits pending argument and the command verdict
  logic closing, close_arg, close_cmd;
  assign closing = sep_end || is_end || end_pend;
  assign close_arg = closing && ahave && pst != P_SKIP && !ovf;
  assign close_cmd = closing && (hlen != 7'h0 || ovf);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_valid <= 1'b0;
      cmd_reject <= 1'b0;
      cmd_query <= 1'b0;
      cmd_id <= '0;
      line_done <= 1'b0;
      line_overflow <= 1'b0;
    end else begin
      cmd_valid <= close_cmd && !(err || ovf || !mif.hit);
      cmd_reject <= close_cmd && (err || ovf || !mif.hit);
      cmd_query <= query;
      cmd_id <= mif.id;
      line_done <= is_end || end_pend;
      line_overflow <= (is_end || end_pend) && ovf;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      arg_valid <= 1'b0;
      arg_kind <= rclp_pkg::ARG_UI;
      arg_neg <= 1'b0;
      arg_value <= 16'h0000;
    end else begin
      arg_valid <= close_arg || (take && pst == P_ARG && u == rclp_pkg::CH_COMMA && ahave);
      arg_kind <= akind;
      arg_neg <= aneg;
      arg_value <= aval[15:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_ready <= 1'b1;
      end_pend <= 1'b0;
    end else begin
      // Data byte carrying EOI needs one more cycle to close the line
      end_pend <= is_last;
      rx_ready <= !is_last;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lcount <= 7'h0;
      ovf <= 1'b0;
    end else if (is_end || end_pend) begin
      lcount <= 7'h0;
      ovf <= 1'b0;
    end else if (take) begin
      if (lcount == 7'(rclp_pkg::MAX_LINE)) begin
        ovf <= 1'b1;
      end else begin
        lcount <= lcount + 7'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pst <= P_HDR;
      hlen <= 7'h0;
      hdr_sp <= 1'b0;
      query <= 1'b0;
      err <= 1'b0;
      ahave <= 1'b0;
      aneg <= 1'b0;
      aval <= 17'h0;
      base <= 5'h0A;
      first_arg <= 1'b1;
      akind <= rclp_pkg::ARG_UI;
    end else if (closing) begin
      pst <= P_HDR;
      hlen <= 7'h0;
      hdr_sp <= 1'b0;
      query <= 1'b0;
      err <= 1'b0;
      ahave <= 1'b0;
      aneg <= 1'b0;
      aval <= 17'h0;
      base <= 5'h0A;
      first_arg <= 1'b1;
      akind <= rclp_pkg::ARG_UI;
    end else if (take && !ovf) begin
      unique case (pst)
        P_HDR: begin
          if (u == rclp_pkg::CH_SP) begin
            if (hlen != 7'h0) begin
              pst <= P_SEP;
              hdr_sp <= 1'b1;
            end
          end else if (u == rclp_pkg::CH_QMARK && hlen != 7'h0) begin
            query <= 1'b1;
            pst <= P_SEP;
          end else begin
            hlen <= hlen + 7'h1;
          end
        end
        P_SEP, P_ARG: begin
          if (u == rclp_pkg::CH_SP) begin
            if (pst == P_SEP) begin
              hdr_sp <= 1'b1;
            end
          end else if (u == rclp_pkg::CH_COMMA) begin
            if (!ahave || pst == P_SEP) begin
              err <= 1'b1;
            end
            ahave <= 1'b0;
            aneg <= 1'b0;
            aval <= 17'h0;
            base <= 5'h0A;
            akind <= rclp_pkg::ARG_UI;
            first_arg <= 1'b0;
            pst <= P_ARG;
          end else begin
            if (pst == P_SEP && !hdr_sp) begin
              err <= 1'b1;
            end
            pst <= P_ARG;
            if (ahave && akind == rclp_pkg::ARG_STR) begin
              err <= 1'b1;
            end else if (u == rclp_pkg::CH_QUOTE && !ahave) begin
              akind <= rclp_pkg::ARG_STR;
              aval <= 17'h0;
              pst <= P_STR;
            end else if (u == rclp_pkg::CH_HASH && !ahave) begin
              akind <= rclp_pkg::ARG_NONDEC;
              pst <= P_BASE;
            end else if ((u == rclp_pkg::CH_PLUS || u == rclp_pkg::CH_MINUS) && !ahave) begin
              akind <= rclp_pkg::ARG_NR1;
              aneg <= u == rclp_pkg::CH_MINUS;
            end else if (u == rclp_pkg::CH_DOT &&
                         (akind == rclp_pkg::ARG_UI || akind == rclp_pkg::ARG_NR1)) begin
              akind <= rclp_pkg::ARG_NR2;
            end else if (u == 8'h45 && ahave && akind != rclp_pkg::ARG_NR3 &&
                         akind != rclp_pkg::ARG_NONDEC) begin
              akind <= rclp_pkg::ARG_NR3;
            end else if ((u == rclp_pkg::CH_PLUS || u == rclp_pkg::CH_MINUS) &&
                         akind == rclp_pkg::ARG_NR3) begin
              ahave <= 1'b1;
            end else if (dig_ok) begin
              ahave <= 1'b1;
              if (akind == rclp_pkg::ARG_UI || akind == rclp_pkg::ARG_NR1 ||
                  akind == rclp_pkg::ARG_NONDEC) begin
                aval <= (acc > 22'(rclp_pkg::UI_MAX)) ? rclp_pkg::VAL_SAT : acc[16:0];
                if (acc > 22'(rclp_pkg::UI_MAX)) begin
                  err <= 1'b1;
                end
                if (akind == rclp_pkg::ARG_NONDEC && acc > 22'(rclp_pkg::ND_MAX)) begin
                  err <= 1'b1;
                end
              end
            end else begin
              err <= 1'b1;
            end
          end
        end
        P_BASE: begin
          pst <= P_ARG;
          unique case (u)
            8'h48: base <= 5'h10;
            8'h51: base <= 5'h08;
            8'h42: base <= 5'h02;
            default: err <= 1'b1;
          endcase
        end
        P_STR: begin
          if (u == rclp_pkg::CH_QUOTE) begin
            ahave <= 1'b1;
            pst <= P_ARG;
          end else if (aval != rclp_pkg::UI_MAX) begin
            aval <= aval + 17'h1;
          end
        end
        P_SKIP: begin
        end
        default: pst <= P_SKIP;
      endcase
    end
  end

  // Response side: pass bytes, then append the chosen end of line
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tst <= T_DATA;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_eoi <= 1'b0;
      resp_ready <= 1'b0;
    end else begin
      resp_ready <= 1'b0;
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
      end
      if (!tx_valid || tx_ready) begin
        unique case (tst)
          T_DATA: begin
            if (resp_valid && resp_ready) begin
              tx_valid <= 1'b1;
              tx_data <= resp_data;
              tx_eoi <= resp_last && port_gpib && !gpib_lf_en;
              if (resp_last && !(port_gpib && !gpib_lf_en)) begin
                tst <= T_EOL1;
              end
            end else begin
              resp_ready <= !resp_ready;
            end
          end
          T_EOL1: begin
            tx_valid <= 1'b1;
            tx_eoi <= port_gpib;
            tst <= T_DATA;
            if (port_gpib) begin
              tx_data <= rclp_pkg::CH_LF;
            end else begin
              tx_data <= (eol_sel == rclp_pkg::EOL_LF || eol_sel == rclp_pkg::EOL_LFCR) ?
                         rclp_pkg::CH_LF : rclp_pkg::CH_CR;
              if (eol_sel == rclp_pkg::EOL_CRLF || eol_sel == rclp_pkg::EOL_LFCR) begin
                tst <= T_EOL2;
              end
            end
          end
          T_EOL2: begin
            tx_valid <= 1'b1;
            tx_eoi <= 1'b0;
            tx_data <= (eol_sel == rclp_pkg::EOL_CRLF) ?
                       rclp_pkg::CH_LF : rclp_pkg::CH_CR;
            tst <= T_DATA;
          end
          default: tst <= T_DATA;
        endcase
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_line_end;
    rx_valid && rx_ready && !port_gpib && rx_data == rclp_pkg::CH_CR;
  endsequence
  sequence s_eoi_data;
    rx_valid && rx_ready && port_gpib && rx_eoi && rx_data != rclp_pkg::CH_LF;
  endsequence

  chk_cr_closes_line: assert property (s_line_end |=> line_done)
    else $error("carriage return did not close the line");
  chk_eoi_data_close: assert property (s_eoi_data |=> !rx_ready ##1 line_done)
    else $error("EOI on data byte did not close the line two cycles on");
  chk_verdict_onehot: assert property (!(cmd_valid && cmd_reject))
    else $error("command both accepted and rejected");
  chk_ovf_rejects: assert property (line_overflow |-> cmd_reject)
    else $error("overlong line not rejected");
  chk_semi_closes: assert property (
      rx_valid && rx_ready && u == rclp_pkg::CH_SEMI && pst == P_HDR && hlen != 7'h0
      |=> cmd_valid || cmd_reject)
    else $error("semicolon did not close the command");
  chk_nondec_range: assert property (
      arg_valid && cmd_valid == 1'b0 && arg_kind == rclp_pkg::ARG_NONDEC && arg_value > 16'h00FF
      |-> ##[0:90] cmd_reject)
    else $error("out of range non-decimal value not rejected");
  chk_gpib_eoi_lf: assert property (
      tx_valid && port_gpib && gpib_lf_en && tx_eoi |-> tx_data == rclp_pkg::CH_LF)
    else $error("GPIB EOI without line feed while line feed selected");
  chk_serial_crlf: assert property (
      tx_valid && tx_ready && !port_gpib && tst == T_EOL2 && eol_sel == rclp_pkg::EOL_CRLF
      |-> tx_data == rclp_pkg::CH_CR ##1 (tx_valid && tx_data == rclp_pkg::CH_LF))
    else $error("serial CR LF ending out of order");
  chk_line_limit: assert property (lcount <= 7'(rclp_pkg::MAX_LINE))
    else $error("line counter passed its limit");
endmodule

// [tb/rclp_host.sv]
module rclp_host (
  input wire logic clock,
  input wire logic arst_n,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_eoi,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_eoi,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] tx_q [$];
  logic [7:0] cyc = 8'h00;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    rx_eoi = 1'b0;
    tx_ready = 1'b0;
  end
  // Sink stalls two cycles in five, so held output bytes are exercised
  always @(posedge clock) begin
    cyc <= cyc + 8'h01;
    tx_ready <= arst_n && (cyc % 5) > 1;
    if (tx_valid && tx_ready) tx_q.push_back({tx_eoi, tx_data});
  end
  // Ready sampled mid-cycle, so the request holds up to the accepting edge
  task automatic put(input logic [7:0] b, input logic eoi);
    logic r;
    rx_valid <= 1'b1;
    rx_data <= b;
    rx_eoi <= eoi;
    do begin
      @(negedge clock);
      r = rx_ready;
      @(posedge clock);
    end while (!r);
  endtask
  // Line length is left to the caller; only overflow cases exceed 80
  task automatic send_line(input byte unsigned ln[$], input logic gpib, input logic lf);
    foreach (ln[i]) put(ln[i], gpib && !lf && i == ln.size() - 1);
    if (!gpib) put(rclp_pkg::CH_CR, 1'b0);
    else if (lf) put(rclp_pkg::CH_LF, 1'b1);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_eoi <= 1'b0;
  endtask
endmodule

// [tb/tb_top.sv]
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
    n_errors++; \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic port_gpib = 1'b0;
  logic [1:0] eol_sel = 2'h0;
  logic gpib_lf_en = 1'b0;
  logic resp_valid = 1'b0;
  logic [7:0] resp_data = 8'h00;
  logic resp_last = 1'b0;
  logic rx_valid, rx_eoi, rx_ready, cmd_valid, cmd_reject, cmd_query, arg_valid, arg_neg;
  logic line_done, line_overflow, resp_ready, tx_valid, tx_eoi, tx_ready;
  logic [7:0] rx_data, tx_data;
  logic [1:0] cmd_id;
  logic [15:0] arg_value;
  rclp_pkg::rclp_arg_t arg_kind;
  int n_errors = 0;
  int n_checks = 0;
  int line_cnt = 0;
  int i, k, n, t, lo, id;
  logic [31:0] seed = 32'hD1D1;
  logic [31:0] r32;
  logic [63:0] c_log = 64'h0, e_cmd;
  logic [79:0] a_log = 80'h0, e_arg;
  logic ovf_seen, q;
  logic [7:0] c;
  logic [8:0] ex [$];
  byte unsigned ln [$];
  string at [9] = '{"0", "65535", "-5", "1.5", "7.0E+6", "#hff", "#Q377", "#B11111111",
    "\"700\""};
  logic [19:0] av [9] = '{20'h00000, 20'h0FFFF, 20'h30005, 20'h40001, 20'h60007, 20'h800FF,
    20'h800FF, 20'h800FF, 20'hA0003};
  string rj [4] = '{"65536", "#H100", "#B100000000", "#Q400"};

  always #20 clock = ~clock;

  rclp_parser dut (.clock(clock), .arst_n(arst_n), .port_gpib(port_gpib), .eol_sel(eol_sel),
    .gpib_lf_en(gpib_lf_en), .rx_valid(rx_valid), .rx_data(rx_data), .rx_eoi(rx_eoi),
    .rx_ready(rx_ready), .cmd_valid(cmd_valid), .cmd_reject(cmd_reject),
    .cmd_query(cmd_query), .cmd_id(cmd_id), .arg_valid(arg_valid), .arg_kind(arg_kind),
    .arg_neg(arg_neg), .arg_value(arg_value), .line_done(line_done),
    .line_overflow(line_overflow), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_last(resp_last), .resp_ready(resp_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_eoi(tx_eoi), .tx_ready(tx_ready));
  rclp_host host (.clock(clock), .arst_n(arst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_eoi(rx_eoi), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_eoi(tx_eoi), .tx_ready(tx_ready));

  // Query bit and id are meaningless on a rejected command, so masked out
  always @(posedge clock) begin
    if (cmd_valid || cmd_reject)
      c_log <= {c_log[59:0], cmd_reject, cmd_query & ~cmd_reject, cmd_id & {2{~cmd_reject}}};
    if (arg_valid) a_log <= {a_log[59:0], 3'(arg_kind), arg_neg, arg_value};
    if (line_done) begin
      line_cnt <= line_cnt + 1;
      ovf_seen <= line_overflow;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic add(input string s);
    foreach (s[j]) ln.push_back(s[j]);
  endtask
  task automatic ec(input logic r, input logic qq, input logic [1:0] ci);
    e_cmd = {e_cmd[59:0], r, qq & ~r, ci & {2{~r}}};
  endtask
  task automatic ea(input logic [2:0] kd, input logic ng, input logic [15:0] v);
    e_arg = {e_arg[59:0], kd, ng, v};
  endtask
  task automatic run(input logic gpib, input logic lf);
    int want;
    @(negedge clock);
    c_log = 64'h0;
    a_log = 80'h0;
    e_cmd = 64'h0;
    e_arg = 80'h0;
    ovf_seen = 1'b0;
    want = line_cnt + 1;
    @(posedge clock);
    port_gpib <= gpib;
    @(posedge clock);
    host.send_line(ln, gpib, lf);
    repeat (200) begin
      @(negedge clock);
      if (line_cnt == want) break;
    end
    repeat (3) @(negedge clock);
    ln.delete();
    `CHK("line_done", want, line_cnt)
  endtask
  task automatic resp_put(input logic [7:0] b, input logic last);
    logic r;
    resp_valid <= 1'b1;
    resp_data <= b;
    resp_last <= last;
    do begin
      @(negedge clock);
      r = resp_ready;
      @(posedge clock);
    end while (!r);
  endtask
  task automatic end_sim();
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    n_errors++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge clock);
    `CHK("rx_ready_rst", 1'b1, rx_ready)
    arst_n <= 1'b1;
    // Full and truncated names in mixed case, unknown headers, then argument forms and ranges
    add("STOP_TEST;");
    run(0, 0);
    ec(0, 0, 1);
    `CHK("cmds", e_cmd, c_log)
    add("start_test; STAT? ;Stop_T");
    run(0, 0);
    ec(0, 0, 0);
    ec(0, 1, 3);
    ec(0, 0, 1);
    `CHK("cmds", e_cmd, c_log)
    add("ou;o;xyz;sto_x");
    run(0, 0);
    ec(0, 0, 2);
    repeat (3) ec(1, 0, 0);
    `CHK("cmds", e_cmd, c_log)
    for (i = 0; i < 9; i++) begin
      add({"out_level ", at[i]});
      run(0, 0);
      ec(0, 0, 2);
      e_arg = {60'h0, av[i]};
      `CHK("cmds", e_cmd, c_log)
      `CHK("arg", e_arg, a_log)
    end
    foreach (rj[j]) begin
      add({"out_level ", rj[j]});
      run(0, 0);
      ec(1, 0, 0);
      `CHK("range", e_cmd, c_log)
    end
    // Host spacing and commas around arguments
    add("OUT_LEVEL   12 ,  #haa , 3");
    run(0, 0);
    ec(0, 0, 2);
    ea(rclp_pkg::ARG_UI, 0, 16'h000C);
    ea(rclp_pkg::ARG_NONDEC, 0, 16'h00AA);
    ea(rclp_pkg::ARG_UI, 0, 16'h0003);
    `CHK("cmds", e_cmd, c_log)
    `CHK("args", e_arg, a_log)
    // STA is shared by two names, so those two start at four characters
    repeat (24) begin
      r32 = rnd();
      id = r32 % 4;
      lo = rclp_pkg::CMD_SIG[id] + (id == 0 || id == 3);
      r32 = rnd();
      t = lo + r32 % (rclp_pkg::CMD_LEN[id] - lo + 1);
      for (k = 0; k < t; k++) begin
        c = rclp_pkg::CMD_NAME[id][(rclp_pkg::CMD_LEN[id] - 1 - k) * 8 +: 8];
        r32 = rnd();
        if (c >= 8'h41 && c <= 8'h5A && r32[0]) c = c | 8'h20;
        ln.push_back(c);
      end
      q = r32[1];
      if (q) ln.push_back(rclp_pkg::CH_QMARK);
      run(0, 0);
      ec(0, q, id[1:0]);
      `CHK("hdr", e_cmd, c_log)
    end
    repeat (16) begin
      r32 = rnd();
      add({"out_level ", $sformatf("%0d", r32[15:0])});
      run(0, 0);
      ec(0, 0, 2);
      ea(rclp_pkg::ARG_UI, 0, r32[15:0]);
      `CHK("ui", {e_cmd, e_arg}, {c_log, a_log})
    end
    for (i = 0; i < 2; i++) begin
      add("stop_test;status?");
      run(1, i[0]);
      ec(0, 0, 1);
      ec(0, 1, 3);
      `CHK("gpib", e_cmd, c_log)
    end
    for (n = 80; n < 82; n++) begin
      add("stop_test");
      repeat (n - 9) add(" ");
      run(0, 0);
      ec(n > 80, 0, 1);
      `CHK("ovf_cmd", e_cmd, c_log)
      `CHK("overflow", n > 80, ovf_seen)
    end
    for (i = 0; i < 6; i++) begin
      @(posedge clock);
      port_gpib <= i > 3;
      eol_sel <= i[1:0];
      gpib_lf_en <= i[0];
      @(posedge clock);
      host.tx_q.delete();
      ex.delete();
      r32 = rnd();
      n = 1 + r32 % 3;
      for (k = 0; k < n; k++) begin
        r32 = rnd();
        c = r32[7:0];
        ex.push_back({i == 4 && k == n - 1, c});
        resp_put(c, k == n - 1);
      end
      resp_valid <= 1'b0;
      resp_data <= ~c;
      resp_last <= 1'b0;
      if (i == 5) ex.push_back({1'b1, rclp_pkg::CH_LF});
      if (i == 1 || i == 3) ex.push_back({1'b0, rclp_pkg::CH_LF});
      if (i == 0 || i == 2 || i == 3) ex.push_back({1'b0, rclp_pkg::CH_CR});
      if (i == 2) ex.push_back({1'b0, rclp_pkg::CH_LF});
      repeat (200) begin
        @(negedge clock);
        if (host.tx_q.size() >= ex.size()) break;
      end
      `CHK("tx_count", ex.size(), host.tx_q.size())
      foreach (ex[j]) `CHK("tx_byte", ex[j], host.tx_q[j])
    end
    end_sim();
  end
endmodule
